// file: core/e1rx_pkg.sv
// Constants and types for the E1 receive system interface
package e1rx_pkg;
  localparam int SYS_PERIOD_NS = 8;
  localparam int MREF_LOSS_NS = 2000;
  localparam int MREF_LOSS_CYCLES = MREF_LOSS_NS / SYS_PERIOD_NS;
  localparam int LOS_ZERO_SLOTS = 32;
  localparam int EXZ_HDB3_ZEROS = 4;
  localparam int EXZ_AMI_ZEROS = 16;
  localparam int HDB3_DELAY = 4;
  localparam int PRBS_WIDTH = 15;
  localparam logic [14:0] PRBS_SEED = 15'h7FFF;
  typedef enum logic [2:0] {
    CLK_LINE = 3'b001,
    CLK_BYPASS = 3'b010,
    CLK_SUBST = 3'b100
  } rclk_src_type;
  typedef enum logic [2:0] {
    TX_DATA = 3'b001,
    TX_ONES = 3'b010,
    TX_PRBS = 3'b100
  } tx_state_type;
endpackage

// file: core/e1rx_dec_if.sv
// Carrier between receive control and line decoder
`timescale 1ns/100ps
interface e1rx_dec_if;
  logic strobe;
  logic pos;
  logic neg;
  logic hdb3_mode;
  logic exz_report;
  logic data;
  logic cv;
  modport dec (input strobe, pos, neg, hdb3_mode, exz_report, output data, cv);
  modport ctl (output strobe, pos, neg, hdb3_mode, exz_report, input data, cv);
endinterface

// file: core/e1rx_line_decoder.sv
// AMI/HDB3 line decoder with violation and excess-zero detection
`timescale 1ns/100ps
module e1rx_line_decoder
  import e1rx_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  e1rx_dec_if.dec dec
);
  logic [HDB3_DELAY-1:0] bits;
  logic [HDB3_DELAY-1:0] flags;
  logic last_pos;
  logic [4:0] zero_cnt;
  logic mark;
  logic both;
  logic viol;
  logic subst;
  logic exz_hit;
  logic cv_now;

  assign mark = dec.pos ^ dec.neg;
  assign both = dec.pos & dec.neg;
  assign viol = mark && (dec.pos == last_pos);
  // Substitution code 000V or B00V
  assign subst = dec.hdb3_mode && viol && (bits[1:0] == 2'b00);
  assign exz_hit = !dec.pos && !dec.neg &&
    (zero_cnt == (dec.hdb3_mode ? 5'(EXZ_HDB3_ZEROS - 1) : 5'(EXZ_AMI_ZEROS - 1)));
  // [RULE3] HDB3 or bipolar violation
  assign cv_now = both || (viol && !subst) || (dec.exz_report && exz_hit);

  // [RULE17] Flags travel with their bit
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bits <= '0;
      flags <= '0;
    end else if (dec.strobe) begin
      bits <= {bits[HDB3_DELAY-2:0] & (subst ? 3'b000 : 3'b111), mark && !subst};
      flags <= {flags[HDB3_DELAY-2:0], cv_now};
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      last_pos <= 1'b0;
      zero_cnt <= '0;
    end else if (dec.strobe) begin
      if (mark) begin
        last_pos <= dec.pos;
        zero_cnt <= '0;
      end else if (!both && zero_cnt != 5'h1F) begin
        zero_cnt <= zero_cnt + 5'h01;
      end
    end
  end

  // [RULE1] Decoded NRZ out of the delay line
  assign dec.data = bits[HDB3_DELAY-1];
  assign dec.cv = flags[HDB3_DELAY-1];
endmodule

// file: core/e1_receive_system_output.sv
// Receive system interface of one E1 channel with reference clock timing
//
// Overview of operation
// [RULE1] Single rail: rx_data_out carries NRZ decoded by AMI or HDB3.
// [RULE2] Single rail: each violation raises code_violation_flag for one receive clock cycle.
// [RULE3] HDB3 mode flags code violations; AMI mode flags bipolar violations.
// [RULE4] Hardware control with single rail also flags excess zeros.
// [RULE5] Dual rail: retimed NRZ with recovery, raw slicer data when bypassed.
// [RULE6] Data changes on selectable clock edge, selectable level; system samples matching edge (e1_framer_model samples the edge opposite the launch edge).
// [RULE7] rx_clock_out is a 2.048 MHz receive clock.
// [RULE8] Signal loss with substitute enable: rx_clock_out comes from master_ref_clock.
// [RULE9] Recovery mode: rx_clock_out is recovered line clock, data launched on it.
// [RULE10] Recovery bypassed: rx_clock_out is XOR of the slicer outputs.
// [RULE11] System supplies master_ref_clock at 2.048 MHz.
// [RULE12] Automatic all ones and alarm signalling always timed from master_ref_clock.
// [RULE13] Hardware control: all ones and PRBS timed from master_ref_clock.
// [RULE14] Lost master_ref_clock puts tx_line_pair into high impedance.
// [RULE15] signal_loss_flag goes high when the received signal is lost.
// [RULE16] signal_loss_flag returns low by itself when signal returns.
// [RULE17] Violation flag aligned with its data bit, same launch edge.
`timescale 1ns/100ps
module e1_receive_system_output
  import e1rx_pkg::*;
#(
  parameter int LOS_SLOTS = LOS_ZERO_SLOTS
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic rx_line_pos,
  input wire logic rx_line_neg,
  input wire logic rec_clock_in,
  input wire logic master_ref_clock,
  input wire logic single_rail_mode,
  input wire logic hdb3_enable,
  input wire logic hardware_control,
  input wire logic clock_data_recovery,
  input wire logic launch_falling_edge,
  input wire logic data_active_low,
  input wire logic alarm_clock_substitute_enable,
  input wire logic all_ones_tx,
  input wire logic auto_all_ones_tx,
  input wire logic prbs_tx,
  input wire logic tx_pos_in,
  input wire logic tx_neg_in,
  output logic rx_data_out,
  output logic code_violation_flag,
  output logic rx_pos_data,
  output logic rx_neg_data,
  output logic rx_clock_out,
  output logic signal_loss_flag,
  output logic tx_line_pos,
  output logic tx_line_neg,
  output logic tx_line_oe_n
);
  if (LOS_SLOTS < 2 || LOS_SLOTS > 255) begin : g_bad_los_slots
    $error("LOS_SLOTS out of range");
  end

  e1rx_dec_if dec_bus ();
  logic [3:0] sync_meta;
  logic [3:0] sync_q;
  logic pos_s;
  logic neg_s;
  logic rclk_s;
  logic mref_s;
  logic mref_prev;
  logic mref_rise;
  logic rclk_prev;
  logic strobe;
  logic launch;
  logic samp_pos;
  logic samp_neg;
  logic pulse_seen;
  logic [7:0] los_cnt;
  logic [8:0] gap_cnt;
  logic mref_lost;
  logic src_level;
  logic ones_pol;
  logic [PRBS_WIDTH-1:0] prbs;
  rclk_src_type rclk_src;
  rclk_src_type next_rclk_src;
  tx_state_type tx_state;
  tx_state_type next_tx_state;

  // Two-stage synchronisers for pins and link clocks
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sync_meta <= '0;
      sync_q <= '0;
    end else begin
      sync_meta <= {master_ref_clock, rec_clock_in, rx_line_neg, rx_line_pos};
      sync_q <= sync_meta;
    end
  end
  assign pos_s = sync_q[0];
  assign neg_s = sync_q[1];
  assign rclk_s = sync_q[2];
  assign mref_s = sync_q[3];
  assign pulse_seen = pos_s | neg_s;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mref_prev <= 1'b0;
    end else begin
      mref_prev <= mref_s;
    end
  end
  assign mref_rise = mref_s & ~mref_prev;

  // [RULE14] Reference clock watchdog
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      gap_cnt <= '0;
      mref_lost <= 1'b0;
    end else if (mref_s != mref_prev) begin
      gap_cnt <= '0;
      mref_lost <= 1'b0;
    end else if (gap_cnt == 9'(MREF_LOSS_CYCLES - 1)) begin
      mref_lost <= 1'b1;
    end else begin
      gap_cnt <= gap_cnt + 9'h001;
    end
  end

  // [RULE15] Count empty slots; [RULE16] any pulse clears
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      los_cnt <= '0;
      signal_loss_flag <= 1'b0;
    end else if (pulse_seen) begin
      los_cnt <= '0;
      signal_loss_flag <= 1'b0;
    end else if (mref_rise && los_cnt != 8'(LOS_SLOTS - 1)) begin
      los_cnt <= los_cnt + 8'h01;
    end else if (mref_rise) begin
      signal_loss_flag <= 1'b1;
    end
  end

  // [RULE8] Receive clock source selection
  always_comb begin
    if (signal_loss_flag && alarm_clock_substitute_enable) begin
      next_rclk_src = CLK_SUBST;
    end else if (clock_data_recovery) begin
      next_rclk_src = CLK_LINE;
    end else begin
      next_rclk_src = CLK_BYPASS;
    end
  end
  // [RULE10] Bypass source is slicer XOR
  always_comb begin
    case (rclk_src)
      CLK_LINE: src_level = rclk_s;
      CLK_BYPASS: src_level = pos_s ^ neg_s;
      CLK_SUBST: src_level = mref_s;
      default: src_level = 1'b0;
    endcase
  end

  // [RULE7] Receive clock follows the selected line, slicer XOR or reference source
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rclk_src <= CLK_LINE;
      rx_clock_out <= 1'b0;
      rclk_prev <= 1'b0;
    end else begin
      rclk_src <= next_rclk_src;
      rx_clock_out <= src_level;
      rclk_prev <= rx_clock_out;
    end
  end

  assign strobe = rx_clock_out & ~rclk_prev & (rclk_src != CLK_BYPASS);
  // [RULE6] Launch edge selection
  assign launch = launch_falling_edge ? (~rx_clock_out & rclk_prev & (rclk_src != CLK_BYPASS)) : strobe;

  // [RULE4] Excess zeros under hardware single rail
  assign dec_bus.exz_report = hardware_control & single_rail_mode;
  assign dec_bus.strobe = strobe;
  assign dec_bus.pos = pos_s;
  assign dec_bus.neg = neg_s;
  assign dec_bus.hdb3_mode = hdb3_enable;

  e1rx_line_decoder u_decoder (
    .clk(clk),
    .sys_rst(sys_rst),
    .dec(dec_bus)
  );

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      samp_pos <= 1'b0;
      samp_neg <= 1'b0;
    end else if (strobe) begin
      samp_pos <= pos_s;
      samp_neg <= neg_s;
    end
  end

  // [RULE9] Data launched on the receive clock
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rx_data_out <= 1'b0;
      code_violation_flag <= 1'b0;
    end else if (!single_rail_mode) begin
      rx_data_out <= 1'b0;
      code_violation_flag <= 1'b0;
    end else if (launch) begin
      // [RULE1] Decoded data with selected level
      rx_data_out <= dec_bus.data ^ data_active_low;
      // [RULE2] Held until the next launch edge
      code_violation_flag <= dec_bus.cv;
    end
  end

  // [RULE5] Dual rail retimed or raw slicer data
  always_ff @(posedge clk) begin
    if (sys_rst || single_rail_mode) begin
      rx_pos_data <= 1'b0;
      rx_neg_data <= 1'b0;
    end else if (rclk_src == CLK_BYPASS) begin
      rx_pos_data <= pos_s ^ data_active_low;
      rx_neg_data <= neg_s ^ data_active_low;
    end else if (launch) begin
      rx_pos_data <= samp_pos ^ data_active_low;
      rx_neg_data <= samp_neg ^ data_active_low;
    end
  end

  // [RULE12] Alarm all ones chosen on signal loss
  always_comb begin
    if (all_ones_tx || (auto_all_ones_tx && signal_loss_flag)) begin
      next_tx_state = TX_ONES;
    end else if (hardware_control && prbs_tx) begin
      next_tx_state = TX_PRBS;
    end else begin
      next_tx_state = TX_DATA;
    end
  end

  // [RULE13] Patterns stepped by reference clock edges
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tx_state <= TX_DATA;
      ones_pol <= 1'b0;
      prbs <= PRBS_SEED;
      tx_line_pos <= 1'b0;
      tx_line_neg <= 1'b0;
    end else begin
      tx_state <= next_tx_state;
      case (tx_state)
        TX_DATA: begin
          tx_line_pos <= tx_pos_in;
          tx_line_neg <= tx_neg_in;
        end
        TX_ONES: begin
          if (mref_rise) begin
            ones_pol <= ~ones_pol;
            tx_line_pos <= ~ones_pol;
            tx_line_neg <= ones_pol;
          end
        end
        TX_PRBS: begin
          if (mref_rise) begin
            prbs <= {prbs[PRBS_WIDTH-2:0], prbs[14] ^ prbs[13]};
            ones_pol <= ones_pol ^ prbs[14];
            tx_line_pos <= prbs[14] & ~ones_pol;
            tx_line_neg <= prbs[14] & ones_pol;
          end
        end
        default: begin
          tx_line_pos <= 1'b0;
          tx_line_neg <= 1'b0;
        end
      endcase
    end
  end

  // [RULE14] Line drivers released without reference
  assign tx_line_oe_n = mref_lost;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence launch_single;
    launch && single_rail_mode && $stable(single_rail_mode);
  endsequence

  cv_hold_slot_a: assert property (code_violation_flag && !launch && single_rail_mode |=> code_violation_flag) // [RULE2]
    else $error("violation flag dropped before next launch");
  data_launch_value_a: assert property (launch_single |=> rx_data_out == $past(dec_bus.data ^ data_active_low)) // [RULE6]
    else $error("data not launched with selected level");
  bypass_clock_xor_a: assert property (rclk_src == CLK_BYPASS && $past(rclk_src) == CLK_BYPASS
    |-> rx_clock_out == $past(pos_s ^ neg_s)) // [RULE10]
    else $error("bypass clock is not slicer xor");
  line_clock_follow_a: assert property (rclk_src == CLK_LINE && $past(rclk_src) == CLK_LINE
    |-> rx_clock_out == $past(rclk_s)) // [RULE9]
    else $error("receive clock not the recovered clock");
  subst_clock_sel_a: assert property (signal_loss_flag && alarm_clock_substitute_enable |=> rclk_src == CLK_SUBST) // [RULE8]
    else $error("substitute clock not selected");
  los_auto_clear_a: assert property (pulse_seen |=> !signal_loss_flag) // [RULE16]
    else $error("loss flag not cleared by pulse");
  los_set_count_a: assert property (los_cnt == 8'(LOS_SLOTS - 1) && mref_rise && !pulse_seen
    |=> signal_loss_flag) // [RULE15]
    else $error("loss flag not raised after empty slots");
  tx_hiz_loss_a: assert property (gap_cnt == 9'(MREF_LOSS_CYCLES - 1) && mref_s == mref_prev
    |=> tx_line_oe_n) // [RULE14]
    else $error("line drivers not released");
  ones_ref_timed_a: assert property (tx_state == TX_ONES && !mref_rise |=> $stable(tx_line_pos)) // [RULE12]
    else $error("all ones not timed by reference");
endmodule

// file: tb/e1_framer_model.sv
// System-side receive sampler for the E1 channel
`timescale 1ns/100ps
module e1_framer_model (
  input wire logic rx_clock_out,
  input wire logic rx_data_out,
  input wire logic code_violation_flag,
  input wire logic launch_falling_edge,
  input wire logic data_active_low,
  input wire logic clear,
  output int ones,
  output int cvs
);
  always @(posedge rx_clock_out or negedge rx_clock_out or posedge clear) begin
    if (clear) begin
      ones = 0;
      cvs = 0;
    end else if (rx_clock_out === launch_falling_edge) begin
      ones += int'(rx_data_out ^ data_active_low);
      cvs += int'(code_violation_flag);
    end
  end
endmodule

// file: tb/tb_top.sv
// Self-checking bench for the E1 receive system interface
`timescale 1ns/100ps
module tb_top;
  import e1rx_pkg::*;
  typedef struct packed {
    logic hdb3;
    logic hw;
    logic fall;
    logic low;
    logic [47:0] sym;
    logic [7:0] ones;
    logic [7:0] cv;
  } row_type;
  logic clk = 0, sys_rst = 1, rx_line_pos = 0, rx_line_neg = 0, rec_clock_in = 0;
  logic master_ref_clock = 0, single_rail_mode = 1, hdb3_enable = 0, hardware_control = 0;
  logic clock_data_recovery = 1, launch_falling_edge = 0, data_active_low = 0;
  logic alarm_clock_substitute_enable = 0, all_ones_tx = 0, auto_all_ones_tx = 0, prbs_tx = 0;
  logic tx_pos_in = 0, tx_neg_in = 0, line_on = 1, ref_on = 1, clear = 0;
  logic rx_data_out, code_violation_flag, rx_pos_data, rx_neg_data, rx_clock_out;
  logic signal_loss_flag, tx_line_pos, tx_line_neg, tx_line_oe_n;
  int fails = 0, checked = 0, ones, cvs, rck, tgl;
  // Symbols per slot: 2 positive, 1 negative, 3 both rails
  row_type rows [9] = '{
    '{0, 0, 0, 0, 48'h9999_0000_0000, 8'h08, 8'h00},
    '{0, 0, 1, 1, 48'h9999_0000_0000, 8'h08, 8'h00},
    '{0, 0, 0, 0, 48'hA000_0000_0000, 8'h02, 8'h01},
    '{0, 1, 0, 0, 48'h4000_0000_0800, 8'h02, 8'h01},
    '{0, 0, 0, 0, 48'h4000_0000_0800, 8'h02, 8'h00},
    '{1, 0, 0, 0, 48'h6020_0000_0000, 8'h02, 8'h00},
    '{1, 0, 0, 0, 48'h7000_0000_0000, 8'h01, 8'h01},
    '{1, 0, 0, 0, 48'hA000_0000_0000, 8'h02, 8'h01},
    '{1, 1, 1, 0, 48'h4000_0000_0000, 8'h01, 8'h01}
  };
  // Slicers and level, then clock, positive and negative outputs
  logic [5:0] byp [5] = '{6'h26, 6'h15, 6'h33, 6'h0B, 6'h2D};

  e1_receive_system_output dut (.clk, .sys_rst, .rx_line_pos, .rx_line_neg, .rec_clock_in,
    .master_ref_clock, .single_rail_mode, .hdb3_enable, .hardware_control, .clock_data_recovery,
    .launch_falling_edge, .data_active_low, .alarm_clock_substitute_enable, .all_ones_tx,
    .auto_all_ones_tx, .prbs_tx, .tx_pos_in, .tx_neg_in, .rx_data_out, .code_violation_flag,
    .rx_pos_data, .rx_neg_data, .rx_clock_out, .signal_loss_flag, .tx_line_pos, .tx_line_neg,
    .tx_line_oe_n);
  e1_framer_model framer (.rx_clock_out, .rx_data_out, .code_violation_flag,
    .launch_falling_edge, .data_active_low, .clear, .ones, .cvs);

  always #4 clk = ~clk;
  always begin
    #62.5;
    rec_clock_in = line_on & ~rec_clock_in;
  end
  always begin
    #244.1;
    master_ref_clock = ref_on & ~master_ref_clock;
  end
  always @(posedge rx_clock_out) rck++;
  always @(tx_line_pos) tgl++;

  task automatic step(int c);
    repeat (c) @(posedge clk);
    #1;
  endtask
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  task automatic send(logic [1:0] s);
    @(negedge rec_clock_in);
    step(1);
    {rx_line_pos, rx_line_neg} = s;
    @(posedge rec_clock_in);
    step(4);
    {rx_line_pos, rx_line_neg} = 2'h0;
  endtask
  task automatic wait_for(string name, ref logic sig, input logic v, input int lim);
    int c;
    c = 0;
    while (sig !== v && c < lim) begin
      step(1);
      c++;
    end
    check(name, sig, v);
  endtask
  task automatic tally_and_finish;
    if (fails == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    #400000;
    fails++;
    tally_and_finish();
  end

  initial begin
    step(6);
    sys_rst = 0;
    step(3);
    foreach (rows[i]) begin
      {hdb3_enable, hardware_control, launch_falling_edge, data_active_low} =
        {rows[i].hdb3, rows[i].hw, rows[i].fall, rows[i].low};
      clear = 1;
      step(40);
      clear = 0;
      for (int s = 0; s < 32; s++) send(s < 24 ? rows[i].sym[47 - 2 * s -: 2] : 2'h0);
      if (rows[i].ones != 8'hFF) check("ones", ones, rows[i].ones);
      check("violations", cvs, rows[i].cv);
    end
    line_on = 0;
    {single_rail_mode, clock_data_recovery} = 2'h0;
    foreach (byp[i]) begin
      {rx_line_pos, rx_line_neg, data_active_low} = byp[i][5:3];
      step(6);
      check("bypass", {rx_clock_out, rx_pos_data, rx_neg_data}, byp[i][2:0]);
    end
    {rx_line_pos, rx_line_neg, data_active_low} = 3'h0;
    {single_rail_mode, clock_data_recovery, alarm_clock_substitute_enable} = 3'h7;
    wait_for("loss_set", signal_loss_flag, 1, 5000);
    rck = 0;
    step(1220);
    check("subst_clock", rck > 17 && rck < 23, 1);
    line_on = 1;
    send(2'h2);
    wait_for("loss_clear", signal_loss_flag, 0, 400);
    single_rail_mode = 0;
    send(2'h1);
    wait_for("dual_neg", rx_neg_data, 1, 40);
    check("dual_pos", rx_pos_data, 0);
    single_rail_mode = 1;
    rck = 0;
    step(1000);
    check("line_clock", rck > 62 && rck < 67, 1);
    hardware_control = 1;
    for (int k = 0; k < 2; k++) begin
      {auto_all_ones_tx, all_ones_tx} = k ? 2'h2 : 2'h1;
      step(200);
      tgl = 0;
      step(1220);
      check("ones_timing", tgl > 17 && tgl < 23, 1);
    end
    {auto_all_ones_tx, all_ones_tx, prbs_tx} = 3'h1;
    step(200);
    tgl = 0;
    step(1220);
    check("prbs_timing", tgl > 7 && tgl < 17, 1);
    {prbs_tx, tx_neg_in} = 2'h1;
    step(3);
    check("tx_data", {tx_line_pos, tx_line_neg}, 2'h1);
    ref_on = 0;
    wait_for("tx_hiz", tx_line_oe_n, 1, 400);
    ref_on = 1;
    wait_for("tx_drive", tx_line_oe_n, 0, 400);
    sys_rst = 1;
    step(3);
    check("reset", {rx_data_out, code_violation_flag, rx_pos_data, rx_neg_data, rx_clock_out,
      signal_loss_flag, tx_line_oe_n}, 0);
    tally_and_finish();
  end
endmodule
